/* bench/ucx_peer.sv */
// ucx_peer: remote serial transceiver on the two pins
// assumes 8N1 framing, BC clocks a bit, lsb first
`timescale 1ns/1ns
module ucx_peer #(
  parameter int BC = 8
) (
  input  wire aclk,
  input  wire line,
  output reg  rxd
);
  integer run = 0;
  integer last_run = 0;
  integer brk_cnt = 0;
  initial rxd = 1'b1;
  // one-cycle runs are the released pin toggling, not traffic
  always @(posedge aclk) begin
    if (!line) run <= run + 1;
    else begin
      if (run > 1) last_run <= run;
      if (run >= 10 * BC) brk_cnt <= brk_cnt + 1;
      run <= 0;
    end
  end
  task send(input [7:0] b);
    integer i;
    @(posedge aclk) rxd <= 1'b0;
    for (i = 0; i < 10; i++) begin
      repeat (BC) @(posedge aclk);
      rxd <= (i < 8) ? b[i] : 1'b1;
    end
    repeat (BC) @(posedge aclk);
  endtask
endmodule // ucx_peer

/* bench/ucx_serial_port_assertions.sv */
// ucx_serial_port_assertions: port-level checks of the serial port
// assumes bind onto ucx_serial_port, one aclk domain
`timescale 1ns/1ns
module ucx_serial_port_assertions (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        tx_pin_out,
  input wire        tx_pin_oe,
  input wire        rx_pin_claim,
  input wire        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // control shadows rebuilt from bus traffic; standby bit may drift
  reg  [7:0] c1;
  reg  [7:0] c2;
  reg  [7:0] aq;
  reg  [7:0] dq;
  reg        awh;
  reg        wh;
  wire       awt = s_axi_awvalid & s_axi_awready;
  wire       wt  = s_axi_wvalid & s_axi_wready;
  wire       art = s_axi_arvalid & s_axi_arready;
  wire       cm  = (awt | awh) & (wt | wh);
  wire [7:0] ca  = awt ? s_axi_awaddr : aq;
  wire [7:0] cd  = wt ? s_axi_wdata[7:0] : dq;
  wire       sw  = c1[7] & c1[5];
  always @(posedge aclk) begin
    if (!aresetn) begin
      c1 <= 8'h00;
      c2 <= 8'h00;
      awh <= 1'b0;
      wh <= 1'b0;
    end else if (cm) begin
      awh <= 1'b0;
      wh <= 1'b0;
      if (ca == 8'h04) c1 <= cd;
      if (ca == 8'h08) c2 <= cd;
    end else begin
      awh <= awh | awt;
      wh <= wh | wt;
    end
    if (awt) aq <= s_axi_awaddr;
    if (wt) dq <= s_axi_wdata[7:0];
  end
  sequence s_wr_take;
    cm && !s_axi_bvalid;
  endsequence
  sequence s_c2_read;
    art && s_axi_araddr == 8'h08;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write answer late");
  a_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_rd_answer: assert property (art |=> s_axi_rvalid [*1])
    else $error("read answer late");
  a_c2_readback: assert property (s_c2_read |=>
    s_axi_rdata[31:8] == 0 && s_axi_rdata[7:2] == $past(c2[7:2]) &&
    s_axi_rdata[0] == $past(c2[0]))
    else $error("control two readback wrong");
  a_irq_no_en: assert property (c2[7:4] == 4'h0 |-> !irq)
    else $error("interrupt without enable");
  a_tx_owned: assert property (c2[3] && (!sw || c1[1]) |-> tx_pin_oe)
    else $error("transmit pin not driven");
  a_sw_listen: assert property (sw && !c1[1] |-> !tx_pin_oe)
    else $error("single wire pin driven");
  a_rx_claim: assert property (rx_pin_claim == (c2[2] && !c1[7]))
    else $error("receive pin claim wrong");
  a_low_owned: assert property (!tx_pin_out && !sw |-> tx_pin_oe)
    else $error("frame bit on released pin");
endmodule // ucx_serial_port_assertions
bind ucx_serial_port ucx_serial_port_assertions u_chk (.*);

/* bench/ucx_serial_port_tb_top.sv */
// ucx_serial_port_tb_top: register and pin scenarios for the serial port
// assumes the design sources and the peer model compiled before
`timescale 1ns/1ns
`include "ucx_defs.vh"
module ucx_serial_port_tb_top;
  localparam int BC = 8;
  localparam [7:0] A_BD = `UCX_OFS_BAUD;
  localparam [7:0] A_C1 = `UCX_OFS_CTRL1;
  localparam [7:0] A_C2 = `UCX_OFS_CTRL2;
  localparam [7:0] A_ST = `UCX_OFS_STAT1;
  localparam [7:0] A_DT = `UCX_OFS_DATA;
  reg  aclk = 0, aresetn = 0, txl = 0;
  reg  [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg  [31:0] s_axi_wdata = 0;
  reg  [3:0] s_axi_wstrb = 4'hF;
  reg  s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg  s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, tx_pin_out, tx_pin_oe, rx_pin_claim, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire rx_pin_in;
  // released pin shows a changing level rather than a held one
  wire tx_pin_in = tx_pin_oe ? tx_pin_out : ~txl;
  logic [1:0] rr;
  integer err_total = 0, samples_checked = 0, cyc = 0;
  ucx_serial_port DUT (.*);
  ucx_peer #(.BC(BC)) peer (.aclk(aclk), .line(tx_pin_in), .rxd(rx_pin_in));
  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) txl <= tx_pin_in;
  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [7:0] a, output logic [31:0] d);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task t_regs;
    logic [31:0] d;
    integer i;
    rd(A_C2, d);
    chk(d, 0);
    for (i = 4; i < 8; i++) begin
      wr(A_C2, 1 << i);
      rd(A_C2, d);
      chk(d, 1 << i);
      chk(irq, i > 5);
    end
    wr(A_ST, 0);
    rd(A_ST, d);
    chk(d[7:6], 2'b11);
    rd(8'h1C, d);
    chk(rr, `UCX_RESP_SLVERR);
    wr(A_C2, 0);
    $display("test regs over");
  endtask
  task t_rx;
    logic [31:0] d;
    integer n;
    wr(A_C2, 8'h24);
    chk(rx_pin_claim, 1);
    peer.send(8'hA5);
    n = 0;
    while (irq !== 1'b1 && n < 20 * BC) begin
      @(posedge aclk);
      n++;
    end
    chk(irq, 1);
    rd(A_ST, d);
    chk(d[5], 1);
    rd(A_DT, d);
    chk(d, 8'hA5);
    chk(irq, 0);
    $display("test rx over");
  endtask
  task t_wake;
    logic [31:0] d;
    wr(A_C2, 0);
    wr(A_C2, 8'h06);
    rd(A_C2, d);
    chk(d[1], 1);
    repeat (12 * BC) @(posedge aclk);
    rd(A_C2, d);
    chk(d[1], 0);
    wr(A_C1, 8'h08);
    wr(A_C2, 8'h06);
    peer.send(8'h12);
    rd(A_ST, d);
    chk(d[5], 0);
    peer.send(8'h92);
    rd(A_ST, d);
    chk(d[5], 1);
    rd(A_C2, d);
    chk(d[1], 0);
    rd(A_DT, d);
    chk(d, 8'h92);
    wr(A_C2, 0);
    $display("test wake over");
  endtask
  task t_brk;
    integer m, n0, l;
    for (m = 0; m < 2; m++) begin
      l = m ? 13 * BC : 10 * BC;
      wr(A_C1, m ? 8'h04 : 8'h00);
      wr(A_C2, 8'h08);
      repeat (12 * BC) @(posedge aclk);
      n0 = peer.brk_cnt;
      wr(A_C2, 8'h09);
      wr(A_C2, 8'h08);
      repeat (40 * BC) @(posedge aclk);
      chk(peer.brk_cnt - n0, 1);
      chk(peer.last_run == l || peer.last_run == 2 * l, 1);
      wr(A_C2, 0);
    end
    wr(A_C1, 0);
    $display("test break over");
  endtask
  task t_drain;
    logic [31:0] d;
    wr(A_C2, 8'h08);
    repeat (12 * BC) @(posedge aclk);
    wr(A_DT, 0);
    wr(A_C2, 0);
    repeat (14 * BC) @(posedge aclk);
    chk(peer.last_run, 9 * BC);
    chk(tx_pin_oe, 0);
    rd(A_ST, d);
    chk(d[7:6], 2'b11);
    wr(A_C2, 8'h08);
    rd(A_ST, d);
    chk(d[6], 0);
    repeat (12 * BC) @(posedge aclk);
    rd(A_ST, d);
    chk(d[6], 1);
    wr(A_C2, 0);
    $display("test drain over");
  endtask
  task t_loop;
    logic [31:0] d;
    wr(A_C1, 8'h80);
    wr(A_C2, 8'h1C);
    chk(rx_pin_claim, 0);
    rd(A_ST, d);
    wr(A_DT, 8'h3C);
    rd(A_ST, d);
    chk(d[7], 0);
    repeat (40 * BC) @(posedge aclk);
    chk(irq, 1);
    rd(A_ST, d);
    chk(d[5:4], 2'b11);
    rd(A_DT, d);
    chk(d, 8'h3C);
    chk(irq, 0);
    wr(A_C2, 0);
    wr(A_C1, 0);
    $display("test loopback over");
  endtask
  task t_single;
    wr(A_C1, 8'hA0);
    wr(A_C2, 8'h0C);
    chk(tx_pin_oe, 0);
    chk(rx_pin_claim, 0);
    wr(A_C1, 8'hA2);
    chk(tx_pin_oe, 1);
    wr(A_C2, 0);
    wr(A_C1, 0);
    $display("test single wire over");
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(A_BD, BC);
    t_regs;
    t_rx;
    t_wake;
    t_brk;
    t_drain;
    t_loop;
    t_single;
    report_and_stop;
  end
endmodule // ucx_serial_port_tb_top

/* design/ucx_defs.vh */
// ucx_defs.vh: offsets, field positions, reset values and frame counts
// assumes inclusion by every serial port design file
`ifndef UCX_DEFS_VH
`define UCX_DEFS_VH

`define UCX_OFS_BAUD     8'h00
`define UCX_OFS_CTRL1    8'h04
`define UCX_OFS_CTRL2    8'h08
`define UCX_OFS_STAT1    8'h0C
`define UCX_OFS_DATA     8'h10

`define UCX_IDX_NONE     3'h0
`define UCX_IDX_BAUD     3'h1
`define UCX_IDX_CTRL1    3'h2
`define UCX_IDX_CTRL2    3'h3
`define UCX_IDX_STAT1    3'h4
`define UCX_IDX_DATA     3'h5

`define UCX_C2_TXE_IE    7
`define UCX_C2_DONE_IE   6
`define UCX_C2_RXF_IE    5
`define UCX_C2_IDLE_IE   4
`define UCX_C2_TX_ON     3
`define UCX_C2_RX_ON     2
`define UCX_C2_STANDBY   1
`define UCX_C2_BREAK     0

`define UCX_C1_LOOP      7
`define UCX_C1_SRC       5
`define UCX_C1_WAKE      3
`define UCX_C1_LONG_BRK  2
`define UCX_C1_SW_DIR    1

`define UCX_BAUD_RST     16'h0010
`define UCX_CTRL1_RST    8'h00
`define UCX_CTRL2_RST    8'h00

`define UCX_BREAK_SHORT  4'hA
`define UCX_BREAK_LONG   4'hD
`define UCX_IDLE_BITS    4'hA

`define UCX_RESP_OKAY    2'h0
`define UCX_RESP_SLVERR  2'h2

`endif

/* design/ucx_serial_port.v */
// ucx_serial_port: serial port control, status, pins and register slave
// assumes an AXI4-Lite master on aclk and pins from outside the domain
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "ucx_defs.vh"
module ucx_serial_port (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        tx_pin_in,
  output wire        tx_pin_out,
  output wire        tx_pin_oe,
  input  wire        rx_pin_in,
  output wire        rx_pin_claim,
  output wire        irq
);
  localparam RX_IDLE  = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA  = 2'h2;
  localparam RX_STOP  = 2'h3;

  function [2:0] reg_index;
    input [7:0] a;
    begin
      case ({a[7:2], 2'b00})
        `UCX_OFS_BAUD:  reg_index = `UCX_IDX_BAUD;
        `UCX_OFS_CTRL1: reg_index = `UCX_IDX_CTRL1;
        `UCX_OFS_CTRL2: reg_index = `UCX_IDX_CTRL2;
        `UCX_OFS_STAT1: reg_index = `UCX_IDX_STAT1;
        `UCX_OFS_DATA:  reg_index = `UCX_IDX_DATA;
        default:        reg_index = `UCX_IDX_NONE;
      endcase
    end
  endfunction

  reg        aw_held;
  reg        w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg [15:0] bit_cycles;
  reg        loopback_sel;
  reg        rx_source_sel;
  reg        wake_sel;
  reg        long_break_sel;
  reg        single_wire_dir;
  reg        tx_empty_irq_en;
  reg        tx_done_irq_en;
  reg        rx_full_irq_en;
  reg        idle_irq_en;
  reg        tx_on;
  reg        rx_on;
  reg        rx_standby;
  reg        break_send;
  reg        tx_buf_empty;
  reg        tx_done;
  reg        rx_buf_full;
  reg        idle_flag;
  reg        overrun;
  reg [4:0]  arm;
  reg [7:0]  tx_buf;
  reg        buf_full;
  reg        idle_queued;
  reg        break_queued;
  reg        tx_hold;
  reg        tx_quiet_q;
  reg [1:0]  rx_state;
  reg [15:0] rx_cnt;
  reg [2:0]  rx_bitn;
  reg [7:0]  rx_shift;
  reg [7:0]  rx_data;
  reg        rx_line_q;
  reg        rx_seen;
  reg [15:0] high_cyc;
  reg [3:0]  high_bits;

  wire        tx_line;
  wire        tx_busy;
  wire [1:0]  pin_raw;
  wire [1:0]  pin_filt;

  // write channel: address and data accepted in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  wire        aw_take = s_axi_awvalid && s_axi_awready;
  wire        w_take  = s_axi_wvalid && s_axi_wready;
  wire [7:0]  wa      = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd      = w_held ? w_data : s_axi_wdata;
  wire [3:0]  ws      = w_held ? w_strb : s_axi_wstrb;
  wire        wr_fire = (aw_held || aw_take) && (w_held || w_take);
  wire [2:0]  wsel    = reg_index(wa);
  wire        wr_c1   = wr_fire && ws[0] && (wsel == `UCX_IDX_CTRL1);
  wire        wr_c2   = wr_fire && ws[0] && (wsel == `UCX_IDX_CTRL2);
  wire        wr_data = wr_fire && ws[0] && (wsel == `UCX_IDX_DATA);

  assign s_axi_arready = !s_axi_rvalid;
  wire        rd_fire = s_axi_arvalid && s_axi_arready;
  wire [2:0]  rsel    = reg_index(s_axi_araddr);
  wire        rd_stat = rd_fire && (rsel == `UCX_IDX_STAT1);
  wire        rd_data = rd_fire && (rsel == `UCX_IDX_DATA);

  wire [7:0] ctrl1_val = {loopback_sel, 1'b0, rx_source_sel, 1'b0,
                          wake_sel, long_break_sel, single_wire_dir, 1'b0};
  wire [7:0] ctrl2_val = {tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en,
                          idle_irq_en, tx_on, rx_on, rx_standby, break_send};
  wire [7:0] stat1_val = {tx_buf_empty, tx_done, rx_buf_full, idle_flag,
                          overrun, 3'b000};

  // transmit scheduling: break before idle before data
  wire tx_run   = tx_on || tx_hold;
  wire go_break = tx_run && !tx_busy &&
                  (break_queued || (break_send && tx_on));
  wire go_idle  = tx_run && !tx_busy && !go_break && idle_queued;
  wire go_data  = tx_run && !tx_busy && !go_break && !go_idle && buf_full;
  wire tx_pend  = tx_busy || buf_full || idle_queued || break_queued;
  wire tx_quiet = !tx_pend && !(break_send && tx_on);
  wire tx_own   = tx_on || tx_hold;
  wire single   = loopback_sel && rx_source_sel;
  wire rise_on  = wr_c2 && wd[`UCX_C2_TX_ON] && !tx_on;

  assign tx_pin_out   = tx_line;
  assign tx_pin_oe    = tx_own && (!single || single_wire_dir);
  assign rx_pin_claim = rx_on && !loopback_sel;

  // receiver source: internal loop, single wire, or own pin
  wire rx_line = loopback_sel ? (rx_source_sel ? pin_filt[1] : tx_line)
                              : pin_filt[0];

  wire rx_tick  = (rx_cnt == 16'h0000);
  wire rx_done  = rx_on && (rx_state == RX_STOP) && rx_tick;
  wire idle_evt = rx_on && (rx_state == RX_IDLE) && rx_line &&
                  (high_bits == `UCX_IDLE_BITS - 4'h1) &&
                  (high_cyc == bit_cycles - 16'h0001);
  wire wake_mark = rx_done && rx_standby && wake_sel && rx_shift[7];
  wire wake_idle = idle_evt && rx_standby && !wake_sel;
  wire deliver   = rx_done && (!rx_standby || wake_mark);
  // a data read in the same cycle, armed by a status read (arm[2]), frees the buffer, so no overrun then
  wire rx_room   = !rx_buf_full || (arm[2] && rd_data);

  assign irq = (tx_empty_irq_en && tx_buf_empty) ||
               (tx_done_irq_en && tx_done) ||
               (rx_full_irq_en && rx_buf_full) ||
               (idle_irq_en && idle_flag);

  assign pin_raw = {tx_pin_in, rx_pin_in};

  // the filtered level moves only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg filt;
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1   <= 1'b1;
          s2   <= 1'b1;
          s3   <= 1'b1;
          filt <= 1'b1;
        end else begin
          s1 <= pin_raw[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            filt <= s3;
          end
        end
      end
      assign pin_filt[g] = filt;
    end
  endgenerate

  ucx_tx u_tx (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .bit_cycles (bit_cycles),
    .go_data    (go_data),
    .go_break   (go_break),
    .go_idle    (go_idle),
    .long_break (long_break_sel),
    .data       (tx_buf),
    .line       (tx_line),
    .busy       (tx_busy)
  );

  // bus slave and configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UCX_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `UCX_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      bit_cycles   <= `UCX_BAUD_RST;
      {loopback_sel, rx_source_sel, wake_sel} <= 3'h0;
      {long_break_sel, single_wire_dir} <= 2'h0;
      {tx_empty_irq_en, tx_done_irq_en} <= 2'h0;
      {rx_full_irq_en, idle_irq_en, tx_on, rx_on} <= 4'h0;
      break_send   <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == `UCX_IDX_NONE) ? `UCX_RESP_SLVERR
                                                : `UCX_RESP_OKAY;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= (rsel == `UCX_IDX_NONE) ? `UCX_RESP_SLVERR
                                                : `UCX_RESP_OKAY;
        case (rsel)
          `UCX_IDX_BAUD:  s_axi_rdata <= {16'h0000, bit_cycles};
          `UCX_IDX_CTRL1: s_axi_rdata <= {24'h000000, ctrl1_val};
          `UCX_IDX_CTRL2: s_axi_rdata <= {24'h000000, ctrl2_val};
          `UCX_IDX_STAT1: s_axi_rdata <= {24'h000000, stat1_val};
          `UCX_IDX_DATA:  s_axi_rdata <= {24'h000000, rx_data};
          default:        s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (wr_fire && (wsel == `UCX_IDX_BAUD)) begin
        if (ws[0]) begin
          bit_cycles[7:0] <= wd[7:0];
        end
        if (ws[1]) begin
          bit_cycles[15:8] <= wd[15:8];
        end
      end
      if (wr_c1) begin
        loopback_sel    <= wd[`UCX_C1_LOOP];
        rx_source_sel   <= wd[`UCX_C1_SRC];
        wake_sel        <= wd[`UCX_C1_WAKE];
        long_break_sel  <= wd[`UCX_C1_LONG_BRK];
        single_wire_dir <= wd[`UCX_C1_SW_DIR];
      end
      // status one writes fall through with no effect
      if (wr_c2) begin
        tx_empty_irq_en <= wd[`UCX_C2_TXE_IE];
        tx_done_irq_en  <= wd[`UCX_C2_DONE_IE];
        rx_full_irq_en  <= wd[`UCX_C2_RXF_IE];
        idle_irq_en     <= wd[`UCX_C2_IDLE_IE];
        tx_on           <= wd[`UCX_C2_TX_ON];
        rx_on           <= wd[`UCX_C2_RX_ON];
        break_send      <= wd[`UCX_C2_BREAK];
      end
    end
  end

  // transmit side queues and flags; a set always beats a clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf       <= 8'h00;
      buf_full     <= 1'b0;
      idle_queued  <= 1'b0;
      break_queued <= 1'b0;
      tx_hold      <= 1'b0;
      tx_quiet_q   <= 1'b1;
      tx_buf_empty <= 1'b1;
      tx_done      <= 1'b1;
      arm          <= 5'h00;
    end else begin
      if (rd_stat) begin
        arm <= stat1_val[7:3];
      end
      if (wr_data) begin
        tx_buf <= wd[7:0];
      end
      if (wr_data) begin
        buf_full <= 1'b1;
      end else if (go_data) begin
        buf_full <= 1'b0;
      end
      if (rise_on) begin
        idle_queued <= 1'b1;
      end else if (go_idle) begin
        idle_queued <= 1'b0;
      end
      if (wr_c2 && wd[`UCX_C2_BREAK] && !break_send) begin
        break_queued <= 1'b1;
      end else if (go_break) begin
        break_queued <= 1'b0;
      end
      // keeps the pin and the scheduler alive while work drains
      tx_hold    <= (tx_on || tx_hold) && tx_pend;
      tx_quiet_q <= tx_quiet;
      if (go_data) begin
        tx_buf_empty <= 1'b1;
      end else if (arm[4] && wr_data) begin
        tx_buf_empty <= 1'b0;
      end
      if (tx_quiet && !tx_quiet_q) begin
        tx_done <= 1'b1;
      end else if (arm[3] && (wr_data || rise_on ||
                   (wr_c2 && wd[`UCX_C2_BREAK]))) begin
        tx_done <= 1'b0;
      end
    end
  end

  // receiver: start detect, mid-bit sampling, eight data bits, stop
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_state  <= RX_IDLE;
      rx_cnt    <= 16'h0000;
      rx_bitn   <= 3'h0;
      rx_shift  <= 8'h00;
      rx_line_q <= 1'b1;
    end else if (!rx_on) begin
      rx_state  <= RX_IDLE;
      rx_line_q <= 1'b1;
    end else begin
      rx_line_q <= rx_line;
      case (rx_state)
        RX_IDLE: begin
          rx_cnt <= {1'b0, bit_cycles[15:1]};
          if (rx_line_q && !rx_line) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (!rx_tick) begin
            rx_cnt <= rx_cnt - 16'h0001;
          end else begin
            rx_cnt   <= bit_cycles - 16'h0001;
            rx_bitn  <= 3'h0;
            // a glitch shorter than half a bit is dropped
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (!rx_tick) begin
            rx_cnt <= rx_cnt - 16'h0001;
          end else begin
            rx_cnt   <= bit_cycles - 16'h0001;
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_bitn  <= rx_bitn + 3'h1;
            if (rx_bitn == 3'h7) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (!rx_tick) begin
            rx_cnt <= rx_cnt - 16'h0001;
          end else begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // idle counting starts from the middle of the stop bit
  always @(posedge aclk) begin
    if (!aresetn) begin
      high_cyc  <= 16'h0000;
      high_bits <= 4'h0;
    end else if (!rx_on || (rx_state != RX_IDLE) || !rx_line) begin
      high_cyc  <= 16'h0000;
      high_bits <= 4'h0;
    end else if (high_bits != `UCX_IDLE_BITS) begin
      if (high_cyc == bit_cycles - 16'h0001) begin
        high_cyc  <= 16'h0000;
        high_bits <= high_bits + 4'h1;
      end else begin
        high_cyc <= high_cyc + 16'h0001;
      end
    end
  end

  // receive flags and standby
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_data     <= 8'h00;
      rx_buf_full <= 1'b0;
      overrun     <= 1'b0;
      idle_flag   <= 1'b0;
      rx_seen     <= 1'b0;
      rx_standby  <= 1'b0;
    end else begin
      if (deliver && rx_room) begin
        rx_data     <= rx_shift;
        rx_buf_full <= 1'b1;
      end else if (arm[2] && rd_data) begin
        rx_buf_full <= 1'b0;
      end
      if (deliver && !rx_room) begin
        overrun <= 1'b1;
      end else if (arm[0] && rd_data) begin
        overrun <= 1'b0;
      end
      // idle reports once per burst of received characters
      if (idle_evt && rx_seen && !rx_standby) begin
        idle_flag <= 1'b1;
        rx_seen   <= 1'b0;
      end else begin
        if (arm[1] && rd_data) begin
          idle_flag <= 1'b0;
        end
        if (deliver && rx_room) begin
          rx_seen <= 1'b1;
        end
      end
      if (wr_c2) begin
        rx_standby <= wd[`UCX_C2_STANDBY];
      end else if (wake_mark || wake_idle) begin
        rx_standby <= 1'b0;
      end
    end
  end
endmodule // ucx_serial_port

/* design/ucx_tx.v */
// ucx_tx: frame shifter for data, break and idle characters
// assumes bit_cycles >= 1 and start requests only while not busy
`timescale 1ns/1ns
`include "ucx_defs.vh"
module ucx_tx (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [15:0] bit_cycles,
  input  wire        go_data,
  input  wire        go_break,
  input  wire        go_idle,
  input  wire        long_break,
  input  wire [7:0]  data,
  output reg         line,
  output wire        busy
);
  reg [12:0] shift;
  reg [3:0]  bits_left;
  reg [15:0] cyc;

  assign busy = (bits_left != 4'h0);

  always @(posedge aclk) begin
    if (!aresetn) begin
      shift     <= 13'h1FFF;
      bits_left <= 4'h0;
      cyc       <= 16'h0000;
      line      <= 1'b1;
    end else if (!busy) begin
      cyc <= 16'h0000;
      if (go_break) begin
        // all zeros, no stop bit inside the break itself
        shift     <= 13'h0000;
        line      <= 1'b0;
        bits_left <= long_break ? `UCX_BREAK_LONG : `UCX_BREAK_SHORT;
      end else if (go_idle) begin
        shift     <= 13'h1FFF;
        line      <= 1'b1;
        bits_left <= `UCX_IDLE_BITS;
      end else if (go_data) begin
        // start bit goes out now, data lsb first then stop
        shift     <= {4'hF, 1'b1, data};
        line      <= 1'b0;
        bits_left <= 4'hA;
      end else begin
        line <= 1'b1;
      end
    end else if (cyc == bit_cycles - 16'h0001) begin
      cyc       <= 16'h0000;
      bits_left <= bits_left - 4'h1;
      shift     <= {1'b1, shift[12:1]};
      line      <= (bits_left == 4'h1) ? 1'b1 : shift[0];
    end else begin
      cyc <= cyc + 16'h0001;
    end
  end
endmodule // ucx_tx
